// ==== pkg/bth_pkg.sv ====
// shared constants and carrier types for the bridge termination handler
package bth_pkg;
  // ==========================================================================
  // configuration space
  localparam logic [7:0] CFG_EVT_DIS = 8'h64;
  localparam logic [7:0] CFG_RETRY_LIMIT = 8'h68;
  localparam logic [7:0] CFG_STATUS = 8'h6C;
  localparam int EVT_DIS_PW_BIT = 2;
  localparam int EVT_DIS_DLY_BIT = 5;
  localparam int CMD_SERR_EN_BIT = 8;
  localparam logic [31:0] EVT_DIS_RESET = 32'h0000_0000;
  // 2^24 attempts; a value of zero stands for 2^32
  localparam logic [31:0] RETRY_LIMIT_RESET = 32'h0100_0000;
  localparam int ST_RCV_TABORT = 0;
  localparam int ST_SIG_TABORT = 1;
  localparam int ST_SIG_SERR = 2;
  localparam int ST_RCV_MABORT = 3;
  localparam int ST_WIDTH = 4;
  // ==========================================================================
  // bus figures
  localparam logic [2:0] DEVSEL_WAIT_CLK = 3'h5;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_MWI = 4'hF;
  localparam logic [3:0] CBE_ALL_BYTES = 4'h0;
  localparam logic [7:0] PW_MIN_ROOM = 8'h02;
  // ==========================================================================
  // types
  typedef enum logic [1:0] {
    K_POSTED = 2'h0,
    K_DLY_WRITE = 2'h1,
    K_DLY_READ = 2'h2
  } bth_kind_e;
  typedef enum logic [2:0] {
    R_ACCEPT = 3'h0,
    R_RETRY = 3'h1,
    R_DISC = 3'h2,
    R_TABORT = 3'h3,
    R_NODEVSEL = 3'h4
  } bth_resp_e;
  typedef enum logic [2:0] {
    T_NORMAL = 3'h0,
    T_RETRY = 3'h1,
    T_DISC = 3'h2,
    T_TABORT = 3'h3,
    T_MABORT = 3'h4
  } bth_term_e;
  typedef struct packed {
    bth_kind_e kind;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [31:0] data;
    logic [7:0] words;
    logic locked;
    logic prefetch;
  } bth_req_s;
  typedef struct packed {
    bth_kind_e kind;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic [31:0] data;
    logic [7:0] words;
    logic prefetch;
    logic [31:0] limit;
  } bth_job_s;
  typedef struct packed {
    bth_term_e term;
    logic [7:0] words;
    logic exhausted;
  } bth_res_s;
endpackage : bth_pkg

// ==== core/bth_sync2.sv ====
// two flip-flop level synchroniser
`timescale 1ns/100ps
module bth_sync2 (
  input wire logic clk_i,   // destination clock
  input wire logic rstn_i,  // destination reset, active low
  input wire logic d_i,     // level from the other domain
  output logic q_o          // synchronised level
);
  logic meta;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 1'b0;
      q_o <= 1'b0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule : bth_sync2

// ==== core/bth_attempt_ctr.sv ====
// attempt counter with programmable limit for non-delivery reporting
`timescale 1ns/100ps
module bth_attempt_ctr (
  input wire logic clk_i,           // link clock
  input wire logic rstn_i,          // link reset, active low
  input wire logic clear_i,         // new transaction taken
  input wire logic inc_i,           // one more attempt made
  input wire logic [31:0] limit_i,  // attempt limit, zero means 2^32
  output logic last_o,              // current attempt is the last allowed
  output logic [31:0] count_o       // attempts made so far
);
  // wraps naturally so a zero limit gives the full 2^32 range
  assign last_o = (count_o == (limit_i - 32'h0000_0001));
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_o <= 32'h0000_0000;
    end else if (clear_i) begin
      count_o <= 32'h0000_0000;
    end else if (inc_i && !last_o) begin
      count_o <= count_o + 32'h0000_0001;
    end
  end

  property p_clear_restarts;
    @(posedge clk_i) disable iff (!rstn_i) clear_i |=> (count_o == 32'h0000_0000);
  endproperty
  a_clear_restarts: assert property (p_clear_restarts) else $error("attempt count not cleared");

  property p_count_steps;
    @(posedge clk_i) disable iff (!rstn_i) (inc_i && !clear_i && !last_o) |=> (count_o == $past(count_o) + 32'h0000_0001);
  endproperty
  a_count_steps: assert property (p_count_steps) else $error("attempt count did not advance");
endmodule : bth_attempt_ctr

// ==== core/bth_termination.sv ====
// bridge transaction termination handler: initiator side, target bus master and error reporting
`timescale 1ns/100ps
module bth_termination import bth_pkg::*; #(
  parameter int MASTER_TIMEOUT_CLK = 32768
) (
  input wire logic clock_i,                 // initiator-side clock
  input wire logic rstn_i,                  // initiator-side reset, active low
  input wire logic tgt_clk_i,               // target bus clock
  input wire logic tgt_rstn_i,              // target bus reset, active low
  input wire logic req_valid_i,             // initiator attempt present
  input wire bth_req_s req_i,               // initiator attempt
  input wire logic lock_prop_i,             // locked sequence propagating
  input wire logic tgt_locked_i,            // target bus locked
  input wire logic slow_accept_i,           // acceptance would exceed 16 clocks
  input wire logic dq_full_i,               // delayed queue full
  input wire logic ret_at_head_i,           // completion at head, no posted write ahead
  input wire logic pf_discard_i,            // prefetched data being discarded
  input wire logic [7:0] pw_room_i,         // posted buffer free entries
  input wire logic boundary_i,              // internal address boundary reached
  output logic resp_valid_o,                // answer to initiator valid
  output bth_resp_e resp_o,                 // answer to initiator
  input wire logic cfg_we_i,                // configuration write
  input wire logic [7:0] cfg_addr_i,        // configuration offset
  input wire logic [31:0] cfg_wdata_i,      // configuration write data
  output logic [31:0] cfg_rdata_o,          // configuration read data
  input wire logic [15:0] cmd_reg_i,        // secondary command register
  output logic primary_system_error_n_o,    // system error pulse, active low
  output logic tgt_frame_n_o,               // target bus frame, active low
  output logic tgt_irdy_n_o,                // target bus initiator ready, active low
  output logic [31:0] tgt_ad_o,             // target bus address and data
  output logic [3:0] tgt_cbe_n_o,           // target bus command and byte enables
  input wire logic tgt_devsel_n_i,          // target device select, active low
  input wire logic tgt_trdy_n_i,            // target ready, active low
  input wire logic tgt_stop_n_i             // target stop, active low
);
  // ==========================================================================
  // initiator side
  typedef enum logic [2:0] {S_IDLE = 3'b001, S_PEND = 3'b010, S_DONE = 3'b100} bth_cstate_e;
  bth_cstate_e cstate, next_cstate;
  bth_job_s job;
  bth_res_s res, res_in;
  logic job_tgl, res_tgl, res_tgl_s, res_tgl_q;
  logic [31:0] evt_dis, retry_limit, to_cnt;
  logic [ST_WIDTH-1:0] status;
  bth_resp_e next_resp;

  function automatic bth_resp_e done_resp(input bth_job_s j, input bth_res_s r, input logic [7:0] want,
                                          input logic bnd);
    bth_resp_e v;
    v = R_ACCEPT;
    case (r.term)
      T_TABORT: v = R_TABORT;
      T_MABORT: v = R_NODEVSEL;
      T_RETRY: v = R_RETRY;
      default: begin
        if (j.kind == K_DLY_WRITE) begin
          v = (want > 8'h01) ? R_DISC : R_ACCEPT;
        end else if (!j.prefetch && r.term == T_NORMAL) begin
          v = R_DISC;
        end else begin
          v = (want > r.words || bnd) ? R_DISC : R_ACCEPT;
        end
      end
    endcase
    return v;
  endfunction : done_resp

  wire is_posted = (req_i.kind == K_POSTED);
  wire same_txn = (req_i.kind == job.kind) && (req_i.addr == job.addr) && (req_i.cmd == job.cmd) &&
                  (req_i.kind == K_DLY_READ || req_i.data == job.data);
  wire lock_block = (lock_prop_i && !req_i.locked) || (tgt_locked_i && req_i.locked && !is_posted);
  wire pw_no_room = (pw_room_i < PW_MIN_ROOM);
  wire [7:0] pw_cap = pw_room_i - 8'h01;
  wire [7:0] pw_words = (req_i.words > pw_cap) ? pw_cap : req_i.words;
  wire dly_block = slow_accept_i || (req_i.kind == K_DLY_READ && pf_discard_i);
  wire slot_idle = (cstate == S_IDLE);
  wire launch = req_valid_i && slot_idle && !lock_block &&
                (is_posted ? !pw_no_room : (!dly_block && !dq_full_i));
  wire deliver = req_valid_i && !is_posted && !lock_block && !dly_block && (cstate == S_DONE) &&
                 same_txn && ret_at_head_i;
  wire res_evt = res_tgl_s ^ res_tgl_q;
  wire timed_out = (cstate == S_DONE) && (to_cnt == 32'(MASTER_TIMEOUT_CLK - 1));
  wire job_posted = (job.kind == K_POSTED);
  wire serr_en = cmd_reg_i[CMD_SERR_EN_BIT];
  wire ev_rcv_tabort = res_evt && (res_in.term == T_TABORT);
  wire ev_rcv_mabort = res_evt && (res_in.term == T_MABORT);
  wire ev_serr_pw = res_evt && job_posted && serr_en &&
                    (res_in.term == T_TABORT || (res_in.exhausted && !evt_dis[EVT_DIS_PW_BIT]));
  wire ev_serr_dly = res_evt && !job_posted && serr_en && res_in.exhausted &&
                     !evt_dis[EVT_DIS_DLY_BIT];
  wire ev_sig_tabort = deliver && (res.term == T_TABORT);
  wire [ST_WIDTH-1:0] st_set = {ev_rcv_mabort, ev_serr_pw | ev_serr_dly, ev_sig_tabort, ev_rcv_tabort};
  wire [ST_WIDTH-1:0] st_clr = (cfg_we_i && cfg_addr_i == CFG_STATUS) ? cfg_wdata_i[ST_WIDTH-1:0] :
                               {ST_WIDTH{1'b0}};

  always_comb begin
    if (lock_block) begin
      next_resp = R_RETRY;
    end else if (is_posted) begin
      if (!slot_idle || pw_no_room) begin
        next_resp = R_RETRY;
      end else if (req_i.words > pw_cap || boundary_i) begin
        next_resp = R_DISC;
      end else begin
        next_resp = R_ACCEPT;
      end
    end else if (deliver) begin
      next_resp = done_resp(job, res, req_i.words, boundary_i);
    end else begin
      next_resp = R_RETRY;
    end
  end

  always_comb begin
    next_cstate = cstate;
    case (cstate)
      S_IDLE: begin
        if (launch) begin
          next_cstate = S_PEND;
        end
      end
      S_PEND: begin
        if (res_evt) begin
          next_cstate = job_posted ? S_IDLE : S_DONE;
        end
      end
      S_DONE: begin
        if (deliver || timed_out) begin
          next_cstate = S_IDLE;
        end
      end
      default: next_cstate = S_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cstate <= S_IDLE;
      job <= '0;
      job_tgl <= 1'b0;
      res <= '0;
      res_tgl_q <= 1'b0;
      to_cnt <= 32'h0000_0000;
    end else begin
      cstate <= next_cstate;
      res_tgl_q <= res_tgl_s;
      to_cnt <= (cstate == S_DONE) ? to_cnt + 32'h0000_0001 : 32'h0000_0000;
      if (launch) begin
        // delayed writes and non-prefetchable reads move one doubleword only
        job <= '{kind: req_i.kind, addr: req_i.addr, cmd: req_i.cmd, data: req_i.data, prefetch: req_i.prefetch,
                 words: is_posted ? pw_words : (req_i.prefetch && req_i.kind == K_DLY_READ) ? req_i.words : 8'h01,
                 limit: retry_limit};
        job_tgl <= ~job_tgl;
      end
      if (res_evt) begin
        res <= res_in;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      resp_valid_o <= 1'b0;
      resp_o <= R_RETRY;
      primary_system_error_n_o <= 1'b1;
      status <= {ST_WIDTH{1'b0}};
    end else begin
      resp_valid_o <= req_valid_i;
      resp_o <= next_resp;
      primary_system_error_n_o <= !(ev_serr_pw || ev_serr_dly);
      status <= (status & ~st_clr) | st_set;  // set wins over a same-cycle clear
    end
  end

  // ==========================================================================
  // configuration registers
  logic [31:0] rd_mux;
  always_comb begin
    if (cfg_addr_i == CFG_EVT_DIS) begin
      rd_mux = evt_dis;
    end else if (cfg_addr_i == CFG_RETRY_LIMIT) begin
      rd_mux = retry_limit;
    end else if (cfg_addr_i == CFG_STATUS) begin
      rd_mux = {{(32 - ST_WIDTH){1'b0}}, status};
    end else begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      evt_dis <= EVT_DIS_RESET;
      retry_limit <= RETRY_LIMIT_RESET;
      cfg_rdata_o <= 32'h0000_0000;
    end else begin
      cfg_rdata_o <= rd_mux;
      if (cfg_we_i && cfg_addr_i == CFG_EVT_DIS) begin
        evt_dis <= cfg_wdata_i;
      end
      if (cfg_we_i && cfg_addr_i == CFG_RETRY_LIMIT) begin
        retry_limit <= cfg_wdata_i;
      end
    end
  end

  bth_sync2 u_res_sync (.clk_i(clock_i), .rstn_i(rstn_i), .d_i(res_tgl), .q_o(res_tgl_s));

  // ==========================================================================
  // target bus master, on the target bus clock
  typedef enum logic [3:0] {L_IDLE = 4'b0001, L_ADDR = 4'b0010, L_DATA = 4'b0100, L_TURN = 4'b1000} bth_lstate_e;
  bth_lstate_e lstate;
  bth_term_e term;
  logic job_tgl_s, job_tgl_q, devsel_seen, ctr_last;
  logic [31:0] cur_addr;
  logic [3:0] cur_cmd;
  logic [7:0] left, xfers;
  logic [2:0] wait_cnt;

  wire job_evt = (lstate == L_IDLE) && (job_tgl_s ^ job_tgl_q);
  wire dsel = !tgt_devsel_n_i;
  wire trdy = !tgt_trdy_n_i;
  wire stop = !tgt_stop_n_i;
  wire l_posted = (job.kind == K_POSTED);
  wire [7:0] remain = left - xfers;
  wire re_try = (term == T_RETRY) || (l_posted && term == T_DISC && remain != 8'h00);
  wire again = (lstate == L_TURN) && re_try && !ctr_last;
  wire finish = (lstate == L_TURN) && !again;
  wire mabort_now = !devsel_seen && !dsel && (wait_cnt == DEVSEL_WAIT_CLK - 3'h1);

  assign tgt_frame_n_o = !((lstate == L_ADDR) || (lstate == L_DATA && (xfers + 8'h01) < left));
  assign tgt_irdy_n_o = (lstate != L_DATA);
  assign tgt_ad_o = (lstate == L_ADDR) ? cur_addr : job.data;
  assign tgt_cbe_n_o = (lstate == L_ADDR) ? cur_cmd : CBE_ALL_BYTES;

  always_ff @(posedge tgt_clk_i or negedge tgt_rstn_i) begin
    if (!tgt_rstn_i) begin
      lstate <= L_IDLE;
      job_tgl_q <= 1'b0;
      res_tgl <= 1'b0;
      res_in <= '0;
      term <= T_NORMAL;
      cur_addr <= 32'h0000_0000;
      cur_cmd <= 4'h0;
      left <= 8'h00;
      xfers <= 8'h00;
      wait_cnt <= 3'h0;
      devsel_seen <= 1'b0;
    end else begin
      case (lstate)
        L_IDLE: begin
          job_tgl_q <= job_tgl_s;
          if (job_evt) begin
            cur_addr <= job.addr;
            cur_cmd <= job.cmd;
            left <= job.words;
            lstate <= L_ADDR;
          end
        end
        L_ADDR: begin
          xfers <= 8'h00;
          wait_cnt <= 3'h0;
          devsel_seen <= 1'b0;
          lstate <= L_DATA;
        end
        L_DATA: begin
          wait_cnt <= wait_cnt + 3'h1;
          devsel_seen <= devsel_seen | dsel;
          if (stop && !dsel && devsel_seen) begin
            term <= T_TABORT;
            lstate <= L_TURN;
          end else if (mabort_now) begin
            term <= T_MABORT;
            lstate <= L_TURN;
          end else if (dsel && stop) begin
            term <= (xfers == 8'h00 && !trdy) ? T_RETRY : T_DISC;
            xfers <= xfers + {7'h00, trdy};
            lstate <= L_TURN;
          end else if (dsel && trdy) begin
            xfers <= xfers + 8'h01;
            if ((xfers + 8'h01) == left) begin
              term <= T_NORMAL;
              lstate <= L_TURN;
            end
          end
        end
        L_TURN: begin
          if (again) begin
            lstate <= L_ADDR;
            if (term == T_DISC) begin
              cur_addr <= cur_addr + {22'h00_0000, xfers, 2'b00};
              left <= remain;
              if (cur_cmd == CMD_MWI) begin
                cur_cmd <= CMD_MEM_WRITE;
              end
            end
          end else begin
            res_in <= '{term: term, words: xfers, exhausted: re_try};
            res_tgl <= ~res_tgl;
            lstate <= L_IDLE;
          end
        end
        default: lstate <= L_IDLE;
      endcase
    end
  end

  bth_sync2 u_job_sync (.clk_i(tgt_clk_i), .rstn_i(tgt_rstn_i), .d_i(job_tgl), .q_o(job_tgl_s));

  bth_attempt_ctr u_ctr (
    .clk_i(tgt_clk_i),
    .rstn_i(tgt_rstn_i),
    .clear_i(job_evt),
    .inc_i(again),
    .limit_i(job.limit),
    .last_o(ctr_last),
    .count_o()
  );

  // ==========================================================================
  // checks
  property p_lock_retry;
    @(posedge clock_i) disable iff (!rstn_i) (req_valid_i && lock_prop_i && !req_i.locked) |=> (resp_valid_o && resp_o == R_RETRY);
  endproperty
  a_lock_retry: assert property (p_lock_retry) else $error("lock propagation not retried");

  property p_pw_room;
    @(posedge clock_i) disable iff (!rstn_i) (req_valid_i && is_posted && pw_no_room) |=> (resp_o == R_RETRY);
  endproperty
  a_pw_room: assert property (p_pw_room) else $error("posted write taken without room");

  property p_slow_retry;
    @(posedge clock_i) disable iff (!rstn_i) (req_valid_i && !is_posted && slow_accept_i) |=> (resp_o == R_RETRY);
  endproperty
  a_slow_retry: assert property (p_slow_retry) else $error("slow delayed request not retried");

  property primary_system_error_out_dly;
    @(posedge clock_i) disable iff (!rstn_i)
      (res_evt && !job_posted && res_in.exhausted && serr_en && !evt_dis[EVT_DIS_DLY_BIT]) |=> !primary_system_error_n_o;
  endproperty
  a_serr_dly: assert property (primary_system_error_out_dly) else $error("delayed non-delivery not reported");

  property p_sig_tabort;
    @(posedge clock_i) disable iff (!rstn_i) (resp_valid_o && resp_o == R_TABORT) |-> status[ST_SIG_TABORT];
  endproperty
  a_sig_tabort: assert property (p_sig_tabort) else $error("signaled abort status missing");

  property p_mabort;
    @(posedge tgt_clk_i) disable iff (!tgt_rstn_i) (lstate == L_ADDR) ##1 (!dsel && lstate == L_DATA) [*5] |=> (term == T_MABORT && lstate == L_TURN);
  endproperty
  a_mabort: assert property (p_mabort) else $error("no master abort after devsel wait");

  property p_retry_same_addr;
    @(posedge tgt_clk_i) disable iff (!tgt_rstn_i) (again && term == T_RETRY) |=> (lstate == L_ADDR && $stable(cur_addr));
  endproperty
  a_retry_same_addr: assert property (p_retry_same_addr) else $error("retry changed address");

  property p_disc_addr;
    @(posedge tgt_clk_i) disable iff (!tgt_rstn_i)
      (again && term == T_DISC) |=> (cur_addr == $past(cur_addr) + {22'h00_0000, $past(xfers), 2'b00});
  endproperty
  a_disc_addr: assert property (p_disc_addr) else $error("restart address not advanced");

  property p_mwi_downgrade;
    @(posedge tgt_clk_i) disable iff (!tgt_rstn_i) (again && term == T_DISC) |=> (cur_cmd != CMD_MWI);
  endproperty
  a_mwi_downgrade: assert property (p_mwi_downgrade) else $error("invalidate command reused");
endmodule : bth_termination

// ==== sim/bth_tgt_model.sv ====
// target bus responder model for the termination bench
`timescale 1ns/100ps
module bth_tgt_model (
  input wire logic clk_i,       // target bus clock
  input wire logic rstn_i,      // target bus reset, active low
  input wire logic frame_n_i,   // frame from bridge
  input wire logic irdy_n_i,    // initiator ready from bridge
  input wire logic [1:0] mode_i, // 0 normal, 1 retry, 2 abort, 3 silent
  output logic devsel_n_o,      // device select, active low
  output logic trdy_n_o,        // target ready, active low
  output logic stop_n_o         // stop, active low
);
  logic [1:0] ph;
  wire logic busy = !frame_n_i || !irdy_n_i;
  // a claiming target holds device select for the whole transfer; an aborting one drops it after one clock, as it asserts stop
  wire logic dev_on = busy && mode_i != 2'h3 && (ph == 2'h0 || mode_i != 2'h2);
  wire logic term = busy && ph == 2'h1;
  // lines go back to their pull-up level once the phase is over
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph <= 2'h0;
      devsel_n_o <= 1'b1;
      trdy_n_o <= 1'b1;
      stop_n_o <= 1'b1;
    end else begin
      ph <= !busy ? 2'h0 : (ph == 2'h3 ? ph : ph + 2'h1);
      devsel_n_o <= !dev_on;
      trdy_n_o <= !(busy && ph != 2'h0 && mode_i == 2'h0);
      stop_n_o <= !(term && (mode_i == 2'h1 || mode_i == 2'h2));
    end
  end
endmodule : bth_tgt_model

// ==== sim/testbench.sv ====
// self-checking bench for the termination handler
`timescale 1ns/100ps
module testbench import bth_pkg::*;;
  logic clock_i = 0, rstn_i = 0, tgt_clk_i = 0, req_valid_i = 0, cfg_we_i = 0;
  logic lock_prop_i = 0, tgt_locked_i = 0, slow_accept_i = 0, dq_full_i = 0, ret_at_head_i = 1;
  logic pf_discard_i = 0, boundary_i = 0, resp_valid_o, serr_n, frame_n, irdy_n, devsel_n, trdy_n, stop_n;
  logic [7:0] pw_room_i = 8'h10, cfg_addr_i = 8'h00;
  logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o, ad, last_addr = 32'h0;
  logic [15:0] cmd_reg_i = 16'h0100;
  logic [3:0] cbe_n;
  logic [1:0] mode = 2'h0;
  bth_req_s req_i = '0;
  bth_resp_e resp_o, got;
  int bad_count = 0, checked = 0, serr_cnt = 0;
  always #50 clock_i = ~clock_i;
  always #40 tgt_clk_i = ~tgt_clk_i;
  always @(negedge serr_n) serr_cnt++;
  // address settles in the same step as frame, so look a little later
  always @(negedge frame_n) #1 last_addr = ad;
  bth_termination #(.MASTER_TIMEOUT_CLK(64)) dut (.clock_i(clock_i), .rstn_i(rstn_i), .tgt_clk_i(tgt_clk_i),
    .tgt_rstn_i(rstn_i), .req_valid_i(req_valid_i), .req_i(req_i), .lock_prop_i(lock_prop_i),
    .tgt_locked_i(tgt_locked_i), .slow_accept_i(slow_accept_i), .dq_full_i(dq_full_i),
    .ret_at_head_i(ret_at_head_i), .pf_discard_i(pf_discard_i), .pw_room_i(pw_room_i), .boundary_i(boundary_i),
    .resp_valid_o(resp_valid_o), .resp_o(resp_o), .cfg_we_i(cfg_we_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cmd_reg_i(cmd_reg_i),
    .primary_system_error_n_o(serr_n), .tgt_frame_n_o(frame_n), .tgt_irdy_n_o(irdy_n), .tgt_ad_o(ad),
    .tgt_cbe_n_o(cbe_n), .tgt_devsel_n_i(devsel_n), .tgt_trdy_n_i(trdy_n), .tgt_stop_n_i(stop_n));
  bth_tgt_model partner (.clk_i(tgt_clk_i), .rstn_i(rstn_i), .frame_n_i(frame_n), .irdy_n_i(irdy_n),
    .mode_i(mode), .devsel_n_o(devsel_n), .trdy_n_o(trdy_n), .stop_n_o(stop_n));
  // ==========================================================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i) {cfg_we_i, cfg_addr_i, cfg_wdata_i} <= {1'b1, a, d};
    @(posedge clock_i) cfg_we_i <= 1'b0;
  endtask : cfg_wr
  task automatic cfg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i) cfg_addr_i <= a;
    repeat (2) @(posedge clock_i);
    #1 d = cfg_rdata_o;
  endtask : cfg_rd
  // one attempt; a missing answer counts as a retry and a mismatch
  task automatic send(input bth_kind_e k, input logic [31:0] a, input logic [7:0] w);
    @(posedge clock_i) {req_valid_i, req_i} <= {1'b1, k, a, CMD_MEM_WRITE, 32'hA5A5_0F0F, w, 2'b00};
    @(posedge clock_i) req_valid_i <= 1'b0;
    #1 got = resp_valid_o === 1'b1 ? resp_o : R_RETRY;
    chk({31'h0, resp_valid_o}, 32'h1);
  endtask : send
  // first attempt launches; the repeat long after collects the final answer
  task automatic ask_twice(input bth_kind_e k, input logic [31:0] a);
    send(k, a, 8'h1);
    repeat (40) @(posedge clock_i);
    send(k, a, 8'h1);
  endtask : ask_twice
  // repeat a retried request unchanged, well within the master timeout
  task automatic until_done(input bth_kind_e k, input logic [31:0] a, input logic [7:0] w);
    for (int i = 0; i < 12; i++) begin
      send(k, a, w);
      if (got !== R_RETRY) break;
      repeat (6) @(posedge clock_i);
    end
  endtask : until_done
  // ==========================================================================
  // main sequence
  logic [31:0] v;
  initial begin
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    cfg_rd(CFG_EVT_DIS, v); chk(v, EVT_DIS_RESET);
    cfg_rd(CFG_RETRY_LIMIT, v); chk(v, RETRY_LIMIT_RESET);
    cfg_rd(8'h70, v); chk(v, 32'h0);
    cfg_wr(CFG_RETRY_LIMIT, 32'h3);
    until_done(K_DLY_WRITE, 32'h100, 8'h1); chk(got, R_ACCEPT);
    until_done(K_DLY_WRITE, 32'h200, 8'h4); chk(got, R_DISC);
    until_done(K_DLY_READ, 32'h300, 8'h1); chk(got, R_DISC);
    mode = 2'h2;
    until_done(K_DLY_READ, 32'h400, 8'h1); chk(got, R_TABORT);
    cfg_rd(CFG_STATUS, v); chk(v[1:0], 2'h3);
    cfg_wr(CFG_STATUS, 32'hF);
    send(K_POSTED, 32'h500, 8'h1); chk(got, R_ACCEPT);
    repeat (40) @(posedge clock_i);
    chk(serr_cnt, 1);
    chk(last_addr, 32'h500);
    mode = 2'h1;
    ask_twice(K_DLY_READ, 32'h600); chk(got, R_RETRY);
    chk(serr_cnt, 2);
    cfg_wr(CFG_EVT_DIS, 32'h20);
    ask_twice(K_DLY_WRITE, 32'h700); chk(got, R_RETRY);
    chk(serr_cnt, 2);
    mode = 2'h3;
    until_done(K_DLY_READ, 32'h800, 8'h1); chk(got, R_NODEVSEL);
    @(posedge clock_i) slow_accept_i <= 1'b1;
    send(K_DLY_READ, 32'h900, 8'h1); chk(got, R_RETRY);
    repeat (20) @(posedge clock_i);
    chk(last_addr, 32'h800);
    @(posedge clock_i) {slow_accept_i, lock_prop_i} <= 2'b01;
    send(K_POSTED, 32'hA00, 8'h1); chk(got, R_RETRY);
    @(posedge clock_i) {lock_prop_i, pw_room_i} <= {1'b0, 8'h1};
    send(K_POSTED, 32'hB00, 8'h1); chk(got, R_RETRY);
    end_of_test();
  end
endmodule : testbench
